// file: wdu_pkg.sv
/*
 * Shared constants for the watchdog unit: register addresses, field
 * positions, reset values, key bytes, timing figures and the unlock states.
 * Assumes an 8-bit special-function-register space with byte addresses.
 */
package wdu_pkg;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'hA1;
	localparam logic [7:0] ADDR_CONTROL = 8'hB6;
	localparam logic [7:0] ADDR_REFRESH = 8'hB7;
	localparam logic [7:0] ADDR_ACCESS_KEY = 8'hF7;
	localparam logic [7:0] ADDR_IRQ_REQ = 8'h97;

	localparam int CTRL_ACTION_BIT = 6;
	localparam int CTRL_ENABLE_BIT = 5;
	localparam int CTRL_DIV_LSB = 0;
	localparam int CTRL_DIV_W = 4;
	localparam logic [7:0] CTRL_RST = 8'h04;

	localparam int CAUSE_POR_BIT = 0;
	localparam int CAUSE_LVR_BIT = 1;
	localparam int CAUSE_SWR_BIT = 2;
	localparam int CAUSE_DOG_BIT = 3;
	localparam int CAUSE_PDR_BIT = 4;
	localparam int CAUSE_W = 5;
	localparam logic [7:0] CAUSE_RST = 8'h00;

	localparam int IRQ_FLAG_BIT = 1;
	localparam logic [7:0] IRQ_RST = 8'h00;

	localparam logic [7:0] REFRESH_KEY = 8'h55;
	localparam logic [7:0] TA_KEY1 = 8'h55;
	localparam logic [7:0] TA_KEY2 = 8'hAA;
	localparam logic [7:0] TA_KEY3 = 8'h5A;

	localparam int COUNT_W = 8;
	localparam int TIMEOUT_TICKS = 256;
	localparam int OSC_KHZ = 250;
	localparam int CLK_KHZ = 50000;
	localparam int OSC_PERIOD_NS = 1000000 / OSC_KHZ;
	localparam int CLK_PERIOD_NS = 1000000 / CLK_KHZ;
	localparam int OSC_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MIN_OSC_CYCLES = 4;

	typedef enum logic [1:0]
	{
		TA_IDLE = 2'b00,
		TA_GOT1 = 2'b01,
		TA_GOT2 = 2'b10,
		TA_OPEN = 2'b11
	} wdu_ta_state_t;
endpackage

// file: wdu_sfr_if.sv
/*
 * Internal write port of the register space, shared by the watchdog core
 * and its unlock sequencer. Assumes one clock for both ends.
 */
interface wdu_sfr_if;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	modport src (output we, output addr, output wdata);
	modport snk (input we, input addr, input wdata);
endinterface

// file: wdu_prescaler.sv
/*
 * Power-of-two divider of the oscillator ticks, giving the counting tick.
 * Assumes osc_tick_i is a one-cycle pulse per oscillator period.
 */
module wdu_prescaler
	import wdu_pkg::*;
#(
	parameter int DIV_W = CTRL_DIV_W,
	parameter int PRE_W = 15
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	input wire logic osc_tick_i,
	input wire logic [DIV_W-1:0] sel_i,
	output logic tick_o
);
	logic [PRE_W-1:0] pre_reg;
	logic [PRE_W-1:0] mask;

	if (PRE_W < (2 ** DIV_W) - 1)
	begin : g_check
		$error("prescaler too narrow for divider field");
	end

	// low sel_i bits set: tick every 2**sel_i oscillator ticks
	for (genvar i = 0; i < PRE_W; i++)
	begin : g_mask
		assign mask[i] = (i < int'(sel_i));
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || clear_i)
			pre_reg <= '0;
		else if (osc_tick_i)
			pre_reg <= pre_reg + PRE_W'(1);
	end

	assign tick_o = osc_tick_i && ((pre_reg & mask) == mask);
endmodule

// file: wdu_keylock.sv
/*
 * Timed-access sequencer: three key bytes in a row open write permission
 * to the control register once. Assumes write strobes last one cycle.
 */
module wdu_keylock
	import wdu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	wdu_sfr_if.snk bus,
	output logic open_o
);
	wdu_ta_state_t state_reg;
	wdu_ta_state_t state_next;
	logic key_wr;

	assign key_wr = bus.we && (bus.addr == ADDR_ACCESS_KEY);

	always_comb
	begin
		state_next = state_reg;
		if (key_wr)
		begin
			case (state_reg)
				TA_GOT1:
					state_next = (bus.wdata == TA_KEY2) ? TA_GOT2 :
						(bus.wdata == TA_KEY1) ? TA_GOT1 : TA_IDLE;
				TA_GOT2:
					state_next = (bus.wdata == TA_KEY3) ? TA_OPEN :
						(bus.wdata == TA_KEY1) ? TA_GOT1 : TA_IDLE;
				default:
					state_next = (bus.wdata == TA_KEY1) ? TA_GOT1 : TA_IDLE;
			endcase
		end
		else if (bus.we && bus.addr == ADDR_CONTROL && state_reg == TA_OPEN)
			state_next = TA_IDLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || clear_i)
			state_reg <= TA_IDLE;
		else
			state_reg <= state_next;
	end

	assign open_o = (state_reg == TA_OPEN);

	property p_close_after_write;
		@(posedge clk_i) disable iff (!rstn_i)
		(open_o && bus.we && bus.addr == ADDR_CONTROL) |=> !open_o;
	endproperty
	a_close_after_write: assert property (p_close_after_write)
		else $error("write permission stayed open after control write");

	property p_open_needs_key3;
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(open_o) |-> ($past(key_wr) && $past(bus.wdata) == TA_KEY3
			&& $past(state_reg) == TA_GOT2);
	endproperty
	a_open_needs_key3: assert property (p_open_needs_key3)
		else $error("write permission opened without full key sequence");
endmodule

// file: wdu_watchdog.sv
/*
 * Watchdog core: 8-bit time-out counter on a divided oscillator tick,
 * control, refresh, timed-access, reset-cause and interrupt-request
 * registers on the special-function-register port.
 * Assumes clk_i is never gated (the CPU clock may stop, this one does not),
 * osc_i is the free-running oscillator level, and the surrounding reset
 * logic acts on wdt_rst_o and reports its other reset sources as pulses.
 */
// What this block does
// - 8-bit counter, overflow requests MCU reset
// - counts from free-running oscillator, also in sleep
// - tick is oscillator over two power select
// - select 0000 divides 1, 1111 divides 32768
// - control register resets to 04h
// - external reset disables, loads reset values into all registers
// - disable option sampled each reset overrides enable
// - enable with option clear starts counting
// - any MCU reset clears software enable
// - once counting, software cannot stop it
// - writing 55h to refresh clears counter
// - reset-mode overflow sets flag, then resets
// - reset flag survives watchdog reset
// - control writable only after 55h AAh 5Ah
// - action bit picks reset or interrupt
// - control: action bit6, enable bit5, divider
// - reset cause flags bits 4..0, reset 00h
// - interrupt mode sets request flag bit 1
module wdu_watchdog
	import wdu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic osc_i,
	input wire logic option_disable_i,
	input wire logic mcu_rst_i,
	input wire logic powerdown_evt_i,
	input wire logic software_rst_evt_i,
	input wire logic low_voltage_evt_i,
	input wire logic power_on_evt_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_we_i,
	input wire logic sfr_re_i,
	output logic [7:0] sfr_rdata_o,
	output logic wdt_rst_o,
	output logic timeout_irq_o,
	output logic running_o
);
	wdu_sfr_if sfr ();

	logic osc_s1_reg;
	logic osc_s2_reg;
	logic osc_s3_reg;
	logic osc_tick;
	logic divided_count_clock;
	logic ta_open;
	logic int_reset;
	logic running;
	logic overflow;
	logic wr_ctrl;
	logic wr_ctrl_locked;
	logic wr_refresh;
	logic wr_cause;
	logic wr_irq;
	logic option_disable_reg;
	logic overflow_action_reg;
	logic software_enable_reg;
	logic [CTRL_DIV_W-1:0] divider_select_reg;
	logic [COUNT_W-1:0] count_reg;
	logic [CAUSE_W-1:0] cause_reg;
	logic [CAUSE_W-1:0] cause_next;
	logic timeout_irq_flag_reg;
	logic dog_rst_reg;
	logic [7:0] rdata_reg;
	logic [7:0] ctrl_view;

	if (OSC_CYCLES < MIN_OSC_CYCLES)
	begin : g_check
		$error("system clock too slow to sample the oscillator");
	end
	if (TIMEOUT_TICKS != 2 ** COUNT_W)
	begin : g_check_cnt
		$error("counter width does not match the time-out");
	end

	assign sfr.we = sfr_we_i;
	assign sfr.addr = sfr_addr_i;
	assign sfr.wdata = sfr_wdata_i;

	// oscillator level into clk_i domain; only stage 2 and 3 are looked at
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_s3_reg <= 1'b0;
		end
		else
		begin
			osc_s1_reg <= osc_i;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg;
		end
	end

	assign osc_tick = osc_s2_reg && !osc_s3_reg;

	// the watchdog's own reset request and any other MCU reset
	assign int_reset = mcu_rst_i || dog_rst_reg;

	wdu_keylock u_keylock
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clear_i(int_reset),
		.bus(sfr),
		.open_o(ta_open)
	);

	assign wr_ctrl = sfr_we_i && (sfr_addr_i == ADDR_CONTROL) && ta_open;
	assign wr_ctrl_locked = sfr_we_i && (sfr_addr_i == ADDR_CONTROL)
		&& !ta_open;
	assign wr_refresh = sfr_we_i && (sfr_addr_i == ADDR_REFRESH)
		&& (sfr_wdata_i == REFRESH_KEY);
	assign wr_cause = sfr_we_i && (sfr_addr_i == ADDR_RESET_CAUSE);
	assign wr_irq = sfr_we_i && (sfr_addr_i == ADDR_IRQ_REQ);

	// disable option caught at every reset, held until the next one
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || int_reset)
			option_disable_reg <= option_disable_i;
	end

	assign running = software_enable_reg && !option_disable_reg;

	// control register
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || int_reset)
		begin
			overflow_action_reg <= CTRL_RST[CTRL_ACTION_BIT];
			software_enable_reg <= CTRL_RST[CTRL_ENABLE_BIT];
			divider_select_reg <= CTRL_RST[CTRL_DIV_LSB +: CTRL_DIV_W];
		end
		else if (wr_ctrl)
		begin
			overflow_action_reg <= sfr_wdata_i[CTRL_ACTION_BIT];
			// a running watchdog keeps its enable
			software_enable_reg <= sfr_wdata_i[CTRL_ENABLE_BIT]
				|| running;
			divider_select_reg <= sfr_wdata_i[CTRL_DIV_LSB +: CTRL_DIV_W];
		end
	end

	wdu_prescaler #(
		.DIV_W(CTRL_DIV_W),
		.PRE_W(15)
	) u_prescaler
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.clear_i(!running || wr_refresh || int_reset),
		.osc_tick_i(osc_tick),
		.sel_i(divider_select_reg),
		.tick_o(divided_count_clock)
	);

	// refresh beats a coincident overflow
	assign overflow = running && divided_count_clock && !wr_refresh
		&& (count_reg == '1);

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i || int_reset || !running || wr_refresh)
			count_reg <= '0;
		else if (divided_count_clock)
			count_reg <= count_reg + COUNT_W'(1);
	end

	// one-cycle reset request, set on the same edge as the flag
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			dog_rst_reg <= 1'b0;
		else
			dog_rst_reg <= overflow && !overflow_action_reg;
	end

	// reset cause flags: software write loads the written value, hardware events set
	always_comb
	begin
		cause_next = cause_reg;
		if (wr_cause)
			cause_next = sfr_wdata_i[CAUSE_W-1:0];
		if (overflow && !overflow_action_reg)
			cause_next[CAUSE_DOG_BIT] = 1'b1;
		if (powerdown_evt_i)
			cause_next[CAUSE_PDR_BIT] = 1'b1;
		if (software_rst_evt_i)
			cause_next[CAUSE_SWR_BIT] = 1'b1;
		if (low_voltage_evt_i)
			cause_next[CAUSE_LVR_BIT] = 1'b1;
		if (power_on_evt_i)
			cause_next[CAUSE_POR_BIT] = 1'b1;
	end

	// not touched by int_reset, so the cause is readable afterwards
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			cause_reg <= CAUSE_RST[CAUSE_W-1:0];
		else
			cause_reg <= cause_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			timeout_irq_flag_reg <= IRQ_RST[IRQ_FLAG_BIT];
		else if (overflow && overflow_action_reg)
			timeout_irq_flag_reg <= 1'b1;
		else if (int_reset)
			timeout_irq_flag_reg <= IRQ_RST[IRQ_FLAG_BIT];
		else if (wr_irq)
			timeout_irq_flag_reg <= sfr_wdata_i[IRQ_FLAG_BIT];
	end

	assign ctrl_view = {1'b0, overflow_action_reg, software_enable_reg, 1'b0,
		divider_select_reg};

	// read data registered; key registers and unmapped addresses read zero
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
			rdata_reg <= 8'h00;
		else if (sfr_re_i)
		begin
			case (sfr_addr_i)
				ADDR_CONTROL:
					rdata_reg <= ctrl_view;
				ADDR_RESET_CAUSE:
					rdata_reg <= {3'h0, cause_reg};
				ADDR_IRQ_REQ:
					rdata_reg <= {6'h00, timeout_irq_flag_reg, 1'b0};
				default:
					rdata_reg <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata_o = rdata_reg;
	assign wdt_rst_o = dog_rst_reg;
	assign timeout_irq_o = timeout_irq_flag_reg;
	assign running_o = running;

	property p_refresh_clears;
		@(posedge clk_i) disable iff (!rstn_i)
		(running && wr_refresh) |=> (count_reg == '0) ##1 !dog_rst_reg;
	endproperty
	a_refresh_clears: assert property (p_refresh_clears)
		else $error("refresh did not clear the counter");

	property p_reset_mode_overflow;
		@(posedge clk_i) disable iff (!rstn_i)
		(overflow && !overflow_action_reg) |=>
			(cause_reg[CAUSE_DOG_BIT] && wdt_rst_o) ##1 !software_enable_reg;
	endproperty
	a_reset_mode_overflow: assert property (p_reset_mode_overflow)
		else $error("reset-mode overflow did not flag and reset");

	property p_irq_mode_overflow;
		@(posedge clk_i) disable iff (!rstn_i)
		(overflow && overflow_action_reg) |=> (timeout_irq_o && !wdt_rst_o);
	endproperty
	a_irq_mode_overflow: assert property (p_irq_mode_overflow)
		else $error("interrupt-mode overflow handled wrongly");

	property p_locked_write_ignored;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_ctrl_locked && !int_reset) |=> $stable(ctrl_view);
	endproperty
	a_locked_write_ignored: assert property (p_locked_write_ignored)
		else $error("control register changed without unlock");

	property p_option_blocks;
		@(posedge clk_i) disable iff (!rstn_i)
		option_disable_reg |-> (!running && count_reg == '0 && !wdt_rst_o);
	endproperty
	a_option_blocks: assert property (p_option_blocks)
		else $error("watchdog ran with disable option set");

	property p_cannot_stop;
		@(posedge clk_i) disable iff (!rstn_i)
		(running && !int_reset) |=> running;
	endproperty
	a_cannot_stop: assert property (p_cannot_stop)
		else $error("running watchdog stopped without reset");

	property p_reset_clears_enable;
		@(posedge clk_i) disable iff (!rstn_i)
		int_reset |=> (!software_enable_reg && ctrl_view == CTRL_RST);
	endproperty
	a_reset_clears_enable: assert property (p_reset_clears_enable)
		else $error("enable survived an MCU reset");

	property p_counts_on_tick;
		@(posedge clk_i) disable iff (!rstn_i)
		(running && !divided_count_clock && !wr_refresh && !int_reset)
			|=> $stable(count_reg);
	endproperty
	a_counts_on_tick: assert property (p_counts_on_tick)
		else $error("counter moved without a counting tick");

	property p_count_step;
		@(posedge clk_i) disable iff (!rstn_i)
		(running && divided_count_clock && !wr_refresh && !int_reset)
			|=> count_reg == $past(count_reg) + COUNT_W'(1);
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not advance by one");

	property p_ext_reset_values;
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> (ctrl_view == CTRL_RST && cause_reg == '0
			&& !timeout_irq_o && !running);
	endproperty
	a_ext_reset_values: assert property (p_ext_reset_values)
		else $error("registers wrong after external reset");

	property p_flag_survives;
		@(posedge clk_i) disable iff (!rstn_i)
		(wdt_rst_o && !wr_cause) |=> cause_reg[CAUSE_DOG_BIT];
	endproperty
	a_flag_survives: assert property (p_flag_survives)
		else $error("watchdog reset flag lost at its own reset");

	property p_cause_read;
		@(posedge clk_i) disable iff (!rstn_i)
		(sfr_re_i && sfr_addr_i == ADDR_RESET_CAUSE) |=>
			(sfr_rdata_o[7:5] == 3'h0
			&& sfr_rdata_o[4:0] == $past(cause_reg));
	endproperty
	a_cause_read: assert property (p_cause_read)
		else $error("reset cause read returned wrong value");
endmodule

// file: wdu_watchdog_tb.sv
/*
 * Self-checking bench for the watchdog unit: register table walk, unlock
 * sequence, reset-cause events, reset and interrupt time-outs, disable
 * option. Assumes the oscillator may run far faster than 250 kHz, as long
 * as each level lasts at least two system clocks, to keep the run short.
 */
module wdu_watchdog_tb
	import wdu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed
	{
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} wdu_row_t;

	localparam logic RD = 1'h0;
	localparam logic WR = 1'h1;
	// oscillator period in system clocks (fast stand-in)
	localparam int OSC_T = 8;
	localparam int NROW = 35;
	localparam wdu_row_t ROWS [NROW] = '{
		'{RD, 8'hA1, 8'h00}, '{RD, 8'hB6, 8'h04}, '{RD, 8'hB7, 8'h00},
		'{RD, 8'hF7, 8'h00}, '{RD, 8'h97, 8'h00}, '{RD, 8'h3C, 8'h00},
		'{WR, 8'hB6, 8'h4F}, '{RD, 8'hB6, 8'h04}, '{WR, 8'hF7, 8'h55},
		'{WR, 8'hF7, 8'hAA}, '{WR, 8'hF7, 8'h5A}, '{WR, 8'hB6, 8'hC1},
		'{RD, 8'hB6, 8'h41}, '{WR, 8'hB6, 8'h02}, '{RD, 8'hB6, 8'h41},
		'{WR, 8'hF7, 8'h55}, '{WR, 8'hF7, 8'h00}, '{WR, 8'hF7, 8'hAA},
		'{WR, 8'hF7, 8'h5A}, '{WR, 8'hB6, 8'h03}, '{RD, 8'hB6, 8'h41},
		'{WR, 8'hF7, 8'h55}, '{WR, 8'hF7, 8'h55}, '{WR, 8'hF7, 8'hAA},
		'{WR, 8'h3C, 8'h77}, '{WR, 8'hF7, 8'h5A}, '{WR, 8'hB6, 8'h1F},
		'{RD, 8'hB6, 8'h0F}, '{WR, 8'hA1, 8'hFF}, '{RD, 8'hA1, 8'h1F},
		'{WR, 8'hA1, 8'h00}, '{WR, 8'h97, 8'hFF}, '{RD, 8'h97, 8'h02},
		'{WR, 8'h97, 8'h00}, '{RD, 8'h97, 8'h00}};
	localparam int EVT_BIT [4] = '{CAUSE_POR_BIT, CAUSE_LVR_BIT,
		CAUSE_SWR_BIT, CAUSE_PDR_BIT};

	logic clk_i = 1'h0;
	logic rstn_i;
	logic osc_i = 1'h0;
	logic option_disable_i;
	logic mcu_rst_i;
	logic [3:0] evt;
	logic [7:0] sfr_addr_i;
	logic [7:0] sfr_wdata_i;
	logic sfr_we_i;
	logic sfr_re_i;
	logic [7:0] sfr_rdata_o;
	logic wdt_rst_o;
	logic timeout_irq_o;
	logic running_o;
	int err_total = 0;
	int compares = 0;
	int cyc = 0;
	int rst_seen = 0;
	int t0;
	int base;

	wdu_watchdog dut_u (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.osc_i(osc_i),
		.option_disable_i(option_disable_i),
		.mcu_rst_i(mcu_rst_i),
		.powerdown_evt_i(evt[3]),
		.software_rst_evt_i(evt[2]),
		.low_voltage_evt_i(evt[1]),
		.power_on_evt_i(evt[0]),
		.sfr_addr_i(sfr_addr_i),
		.sfr_wdata_i(sfr_wdata_i),
		.sfr_we_i(sfr_we_i),
		.sfr_re_i(sfr_re_i),
		.sfr_rdata_o(sfr_rdata_o),
		.wdt_rst_o(wdt_rst_o),
		.timeout_irq_o(timeout_irq_o),
		.running_o(running_o)
	);

	always #10 clk_i = ~clk_i;
	always #(OSC_T * 10) osc_i = ~osc_i;

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (wdt_rst_o === 1'h1)
			rst_seen <= rst_seen + 1;
	end

	task automatic report_and_stop();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error t=%0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		sfr_we_i = 1'h1;
		sfr_addr_i = a;
		sfr_wdata_i = d;
		@(posedge clk_i);
		#1;
		sfr_we_i = 1'h0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		#1;
		sfr_re_i = 1'h1;
		sfr_addr_i = a;
		@(posedge clk_i);
		#1;
		sfr_re_i = 1'h0;
		chk(sfr_rdata_o, exp, $sformatf("read of %h", a));
	endtask

	task automatic unlock();
		wr(ADDR_ACCESS_KEY, TA_KEY1);
		wr(ADDR_ACCESS_KEY, TA_KEY2);
		wr(ADDR_ACCESS_KEY, TA_KEY3);
	endtask

	task automatic pulse_rst(input logic ext);
		@(posedge clk_i);
		#1;
		if (ext)
			rstn_i = 1'h0;
		else
			mcu_rst_i = 1'h1;
		repeat (ext ? 2 : 1) @(posedge clk_i);
		#1;
		rstn_i = 1'h1;
		mcu_rst_i = 1'h0;
	endtask

	// waits for a time-out output, counted in clocks from start
	task automatic wait_out(input logic irq, input int start,
		input int lo, input int hi);
		logic hit;
		hit = 1'h0;
		while (!hit && cyc - start <= hi)
		begin
			@(posedge clk_i);
			#1;
			hit = irq ? (timeout_irq_o === 1'h1) : (wdt_rst_o === 1'h1);
		end
		compares++;
		if (!hit || cyc - start < lo)
		begin
			err_total++;
			$display("Error t=%0t time-out after %0d clocks, want %0d..%0d",
				$time, cyc - start, lo, hi);
		end
		t0 = cyc;
		if (!hit)
			report_and_stop();
	endtask

	initial
	begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end

	initial
	begin
		rstn_i = 1'h0;
		option_disable_i = 1'h0;
		mcu_rst_i = 1'h0;
		evt = 4'h0;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		sfr_we_i = 1'h0;
		sfr_re_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
		rstn_i = 1'h1;
		for (int i = 0; i < NROW; i++)
		begin
			if (ROWS[i].wr)
				wr(ROWS[i].addr, ROWS[i].data);
			else
				rchk(ROWS[i].addr, ROWS[i].data);
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			#1;
			evt = 4'h1 << i;
			@(posedge clk_i);
			#1;
			evt = 4'h0;
			rchk(ADDR_RESET_CAUSE, 8'h01 << EVT_BIT[i]);
			wr(ADDR_RESET_CAUSE, 8'h00);
		end
		// reset mode, divide by 1; a late refresh postpones the time-out
		unlock();
		wr(ADDR_CONTROL, 8'h20);
		chk({7'h00, running_o}, 8'h01, "running after enable");
		unlock();
		wr(ADDR_CONTROL, 8'h00);
		chk({7'h00, running_o}, 8'h01, "running after disable");
		repeat (200 * OSC_T) @(posedge clk_i);
		wr(ADDR_REFRESH, REFRESH_KEY);
		t0 = cyc;
		wait_out(1'h0, t0, 256 * OSC_T - 16, 256 * OSC_T + 24);
		rchk(ADDR_RESET_CAUSE, 8'h08);
		rchk(ADDR_CONTROL, CTRL_RST);
		chk({7'h00, running_o}, 8'h00, "running after time-out");
		// divide by 2 doubles the time-out
		unlock();
		wr(ADDR_CONTROL, 8'h21);
		t0 = cyc;
		wait_out(1'h0, t0, 512 * OSC_T - 16, 512 * OSC_T + 24);
		unlock();
		wr(ADDR_CONTROL, 8'h20);
		pulse_rst(1'h0);
		chk({7'h00, running_o}, 8'h00, "running after mcu reset");
		rchk(ADDR_RESET_CAUSE, 8'h08);
		// interrupt mode: flag instead of reset, counter keeps wrapping
		unlock();
		wr(ADDR_CONTROL, 8'h60);
		t0 = cyc;
		wait_out(1'h1, t0, 256 * OSC_T - 16, 256 * OSC_T + 24);
		base = t0;
		rchk(ADDR_IRQ_REQ, 8'h02);
		wr(ADDR_IRQ_REQ, 8'h00);
		chk({7'h00, timeout_irq_o}, 8'h00, "irq after clear");
		repeat (100 * OSC_T) @(posedge clk_i);
		// a wrong refresh key must not move the next time-out
		wr(ADDR_REFRESH, 8'hAA);
		wait_out(1'h1, base, 256 * OSC_T - 16, 256 * OSC_T + 24);
		chk(8'(rst_seen), 8'h02, "reset pulses in irq mode");
		// disable option wins over software enable
		option_disable_i = 1'h1;
		pulse_rst(1'h1);
		rchk(ADDR_RESET_CAUSE, CAUSE_RST);
		unlock();
		wr(ADDR_CONTROL, 8'h20);
		rchk(ADDR_CONTROL, 8'h20);
		chk({7'h00, running_o}, 8'h00, "running with option");
		repeat (270 * OSC_T) @(posedge clk_i);
		chk(8'(rst_seen), 8'h02, "reset pulses with option");
		report_and_stop();
	end
endmodule
